// ### flash_ctl_defs.vh
// constants for the flash write and erase controller
// What this block does
// - programming only clears bits; erase sets every covered byte to 0xff
// - write and erase durations are counted by hardware
// - busy flag reads one while a write or erase runs, except in the one cycle a write reads the old byte
// - fetches stall during an operation; fetch_miss_i is ignored, so cached code stalls too
// - uncached interrupts are held pending until the operation completes
// - write enable set sends move writes to flash, else to aux ram
// - write enable holds until software clears it
// - move reads always return auxiliary ram data
// - flash write or erase with supply monitor off causes error reset
// - key register needs 0xa5 then 0xf1 before an operation
// - time between the two key writes does not matter
// - page erase: set write and erase enables, then write into page
// - array is 32 kB on large variants, 16 kB on small ones
// - an uninitialised part is programmed only over the debug port
`ifndef FLASH_CTL_DEFS_VH
`define FLASH_CTL_DEFS_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CONTROL 4'h0
`define OFS_KEY 4'h4
`define OFS_STATUS 4'h8
// ****************************************
// fields
// ****************************************
`define BIT_WE 0
`define BIT_EE 1
`define BIT_BUSY 0
`define BIT_LOCKED 1
`define BIT_ERR 2
`define KEY_FIRST 8'ha5
`define KEY_SECOND 8'hf1
`define ERASED_BYTE 8'hff
`define RESERVED_BASE 16'h7c00
`define RESERVED_SIZE 16'h0400
// ****************************************
// timing (in ns) and derived cycle counts at 100 mhz
// ****************************************
`define CLK_NS 10
`define T_WRITE_NS 40000
`define T_ERASE_NS 20000000
`define WRITE_CYC ((`T_WRITE_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASE_CYC ((`T_ERASE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### flash_write_erase_control.v
// flash write and erase sequencer with avalon-mm register slave
`timescale 1ns/10ps
`include "flash_ctl_defs.vh"
module flash_write_erase_control #(
	parameter ADDR_W = 15,
	parameter PAGE_W = 9,
	parameter WRITE_CYCLES = `WRITE_CYC,
	parameter ERASE_CYCLES = `ERASE_CYC
) (
	input wire mclk_i,
	input wire nrst_i,
	// register slave
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	// core external-move port
	input wire xmv_req_i,
	input wire xmv_we_i,
	input wire [15:0] xmv_addr_i,
	input wire [7:0] xmv_wdata_i,
	output reg xmv_ack_o,
	output reg [7:0] xmv_rdata_o,
	// auxiliary data ram port
	output reg auxiliary_data_ram_we_o,
	output reg auxiliary_data_ram_re_o,
	output reg [15:0] auxiliary_data_ram_addr_o,
	output reg [7:0] auxiliary_data_ram_wdata_o,
	input wire [7:0] auxiliary_data_ram_rdata_i,
	// flash array port
	output reg fl_prog_o,
	output reg fl_erase_o,
	output reg [ADDR_W-1:0] fl_addr_o,
	output reg [7:0] fl_wdata_o,
	input wire [7:0] fl_rdata_i,
	// fetch and interrupt side
	input wire fetch_miss_i,
	output reg fetch_stall_o,
	output reg irq_hold_o,
	// supply monitor and reset system
	input wire vdd_mon_en_i,
	output reg flash_err_reset_o
);
	// ****************************************
	// state and registers
	// ****************************************
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_READ = 4'h2;
	localparam [3:0] ST_PROG = 4'h4;
	localparam [3:0] ST_ERASE = 4'h8;
	reg [3:0] state_ff, nxt_state;
	reg we_ff, nxt_we;
	reg ee_ff, nxt_ee;
	reg [1:0] key_ff, nxt_key; // 0 none, 1 first seen, 2 unlocked, 3 locked out
	reg err_ff, nxt_err;
	reg [24:0] cnt_ff, nxt_cnt;
	reg [ADDR_W-1:0] addr_ff, nxt_addr;
	reg [7:0] data_ff, nxt_data;
	reg rd_pend_ff;
	wire busy = state_ff[2] | state_ff[3];
	// a write lands on the edge that completes the transfer, with waitrequest low
	wire bus_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
	wire bus_rd = avs_read_i & avs_waitrequest_o;
	wire [7:0] merged = data_ff & fl_rdata_i;
	// ****************************************
	// next state
	// ****************************************
	always @* begin
		nxt_state = state_ff;
		nxt_we = we_ff;
		nxt_ee = ee_ff;
		nxt_key = key_ff;
		nxt_err = 1'b0;
		nxt_cnt = cnt_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		if (bus_wr && avs_address_i == `OFS_CONTROL) begin
			nxt_we = avs_writedata_i[`BIT_WE];
			nxt_ee = avs_writedata_i[`BIT_EE];
		end
		// software operations need the key; the debug port path lives outside this block
		if (bus_wr && avs_address_i == `OFS_KEY) begin
			case (key_ff)
				2'd0: nxt_key = (avs_writedata_i[7:0] == `KEY_FIRST) ? 2'd1 : 2'd3;
				2'd1: nxt_key = (avs_writedata_i[7:0] == `KEY_SECOND) ? 2'd2 : 2'd3;
				default: nxt_key = 2'd3;
			endcase
		end
		case (state_ff)
			ST_IDLE: begin
				if (xmv_req_i && xmv_we_i && we_ff) begin
					if (!vdd_mon_en_i) begin
						nxt_err = 1'b1;
					end else if (key_ff == 2'd2) begin
						nxt_key = 2'd0; // one operation per unlock
						nxt_addr = xmv_addr_i[ADDR_W-1:0];
						nxt_data = xmv_wdata_i;
						nxt_cnt = 25'd0;
						nxt_state = ee_ff ? ST_ERASE : ST_READ;
					end else begin
						nxt_key = 2'd3;
					end
				end
			end
			ST_READ: begin
				// old byte is on the array port now, so the first program cycle is already merged
				nxt_data = merged;
				nxt_state = ST_PROG;
			end
			ST_PROG: begin
				nxt_data = merged;
				nxt_cnt = cnt_ff + 25'd1;
				if (cnt_ff == WRITE_CYCLES - 1) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_ERASE: begin
				nxt_data = `ERASED_BYTE;
				nxt_cnt = cnt_ff + 25'd1;
				if (cnt_ff == ERASE_CYCLES - 1) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end
	// ****************************************
	// registers and outputs
	// ****************************************
	always @(posedge mclk_i) begin
		if (!nrst_i) begin
			state_ff <= ST_IDLE;
			we_ff <= 1'b0;
			ee_ff <= 1'b0;
			key_ff <= 2'd0;
			err_ff <= 1'b0;
			cnt_ff <= 25'd0;
			addr_ff <= {ADDR_W{1'b0}};
			data_ff <= 8'h00;
			rd_pend_ff <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
			avs_waitrequest_o <= 1'b1;
			xmv_ack_o <= 1'b0;
			xmv_rdata_o <= 8'h00;
			auxiliary_data_ram_we_o <= 1'b0;
			auxiliary_data_ram_re_o <= 1'b0;
			auxiliary_data_ram_addr_o <= 16'h0000;
			auxiliary_data_ram_wdata_o <= 8'h00;
			fl_prog_o <= 1'b0;
			fl_erase_o <= 1'b0;
			fl_addr_o <= {ADDR_W{1'b0}};
			fl_wdata_o <= 8'h00;
			fetch_stall_o <= 1'b0;
			irq_hold_o <= 1'b0;
			flash_err_reset_o <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			we_ff <= nxt_we;
			ee_ff <= nxt_ee;
			key_ff <= nxt_key;
			err_ff <= nxt_err;
			cnt_ff <= nxt_cnt;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			// one wait cycle, then the answer; waitrequest drops for one edge
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
			if (bus_rd) begin
				case (avs_address_i)
					`OFS_CONTROL: avs_readdata_o <= {30'd0, ee_ff, we_ff};
					`OFS_KEY: avs_readdata_o <= 32'h0000_0000;
					`OFS_STATUS: avs_readdata_o <= {29'd0, err_ff, key_ff == 2'd3, busy};
					default: avs_readdata_o <= 32'h0000_0000;
				endcase
			end
			// move port: writes ack once taken; reads ack after ram answers
			auxiliary_data_ram_we_o <= 1'b0;
			auxiliary_data_ram_re_o <= 1'b0;
			xmv_ack_o <= 1'b0;
			rd_pend_ff <= 1'b0;
			if (state_ff == ST_IDLE && xmv_req_i && !xmv_ack_o && !rd_pend_ff && !auxiliary_data_ram_re_o) begin
				auxiliary_data_ram_addr_o <= xmv_addr_i;
				auxiliary_data_ram_wdata_o <= xmv_wdata_i;
				if (xmv_we_i) begin
					auxiliary_data_ram_we_o <= ~we_ff;
					xmv_ack_o <= 1'b1;
				end else begin
					auxiliary_data_ram_re_o <= 1'b1;
				end
			end
			if (auxiliary_data_ram_re_o) begin
				rd_pend_ff <= 1'b1;
			end
			if (rd_pend_ff) begin
				xmv_rdata_o <= auxiliary_data_ram_rdata_i;
				xmv_ack_o <= 1'b1;
			end
			// flash array drive
			fl_addr_o <= (nxt_state == ST_ERASE) ? {nxt_addr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}} : nxt_addr;
			fl_wdata_o <= (nxt_state == ST_ERASE) ? `ERASED_BYTE : nxt_data;
			fl_prog_o <= (nxt_state == ST_PROG);
			fl_erase_o <= (nxt_state == ST_ERASE);
			fetch_stall_o <= nxt_state[2] | nxt_state[3] | nxt_state[1];
			irq_hold_o <= nxt_state[2] | nxt_state[3] | nxt_state[1];
			flash_err_reset_o <= nxt_err;
		end
	end
endmodule // flash_write_erase_control

// ### flash_write_erase_control_props.sv
// port assertions for the flash controller
`timescale 1ns/10ps
module flash_write_erase_control_props #(parameter PAGE_W = 9) (
	input wire mclk_i, nrst_i, fl_prog_o, fl_erase_o, fetch_stall_o, irq_hold_o, vdd_mon_en_i, flash_err_reset_o,
	input wire [14:0] fl_addr_o,
	input wire [7:0] fl_wdata_o, fl_rdata_i
);
	wire op = fl_prog_o | fl_erase_o;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	a_op_stall: assert property (op |-> fetch_stall_o) else $error("stall");
	a_op_irq: assert property (op |-> irq_hold_o) else $error("hold");
	a_prog_len: assert property ($rose(fl_prog_o) |-> fl_prog_o[*8] ##1 !fl_prog_o) else $error("length");
	a_prog_clear: assert property ($rose(fl_prog_o) |-> !(fl_wdata_o & ~fl_rdata_i)) else $error("set");
	a_erase_fill: assert property (fl_erase_o |-> fl_wdata_o == 8'hff) else $error("fill");
	a_erase_page: assert property (fl_erase_o |-> !fl_addr_o[PAGE_W-1:0]) else $error("page");
	a_vdd_guard: assert property ($rose(op) |-> vdd_mon_en_i) else $error("vdd");
	a_err_quiet: assert property (flash_err_reset_o |-> !op[*2]) else $error("write");
	c_prog: cover property ($rose(fl_prog_o));
	c_erase: cover property ($rose(fl_erase_o));
	c_err: cover property (flash_err_reset_o);
endmodule // flash_write_erase_control_props

// ### mem_side_model.sv
// flash array and aux ram behind the controller
`timescale 1ns/10ps
module mem_side_model (
	input wire mclk_i, fl_prog_o, fl_erase_o, auxiliary_data_ram_we_o, auxiliary_data_ram_re_o,
	input wire [14:0] fl_addr_o,
	input wire [15:0] auxiliary_data_ram_addr_o,
	input wire [7:0] fl_wdata_o, auxiliary_data_ram_wdata_o,
	output wire [7:0] fl_rdata_i,
	output reg [7:0] auxiliary_data_ram_rdata_i
);
	reg [7:0] fm [0:32767];
	reg [7:0] xm [0:65535];
	integer i;
	initial for (i = 0; i < 32768; i = i + 1) fm[i] = 8'hff;
	assign fl_rdata_i = fm[fl_addr_o];
	always @(posedge mclk_i) begin
		if (fl_prog_o) fm[fl_addr_o] <= fl_wdata_o;
		if (fl_erase_o) for (i = 0; i < 512; i = i + 1) fm[fl_addr_o + i] <= 8'hff;
		if (auxiliary_data_ram_we_o) xm[auxiliary_data_ram_addr_o] <= auxiliary_data_ram_wdata_o;
		// outside a read the data toggles so a stale byte never looks valid
		auxiliary_data_ram_rdata_i <= auxiliary_data_ram_re_o ? xm[auxiliary_data_ram_addr_o] : ~auxiliary_data_ram_rdata_i;
	end
endmodule // mem_side_model

// ### flash_write_erase_control_tb.sv
// self-checking bench for the flash controller
`timescale 1ns/10ps
`define C(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module flash_write_erase_control_tb;
	reg mclk_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0, xmv_req_i = 0, xmv_we_i = 0;
	// supply monitor on by default; no interrupts or oscillator switching are modelled
	reg fetch_miss_i = 0, vdd_mon_en_i = 1, es = 0;
	reg [3:0] avs_address_i = 0, avs_byteenable_i = 4'hf;
	reg [31:0] avs_writedata_i = 0, r;
	reg [15:0] xmv_addr_i = 0;
	reg [7:0] xmv_wdata_i = 0, d, ev;
	wire avs_waitrequest_o, xmv_ack_o, auxiliary_data_ram_we_o, auxiliary_data_ram_re_o, fl_prog_o, fl_erase_o, fetch_stall_o, irq_hold_o, flash_err_reset_o;
	wire [31:0] avs_readdata_o;
	wire [7:0] xmv_rdata_o, auxiliary_data_ram_wdata_o, auxiliary_data_ram_rdata_i, fl_wdata_o, fl_rdata_i;
	wire [15:0] auxiliary_data_ram_addr_o;
	wire [14:0] fl_addr_o;
	wire [7:0] fb = i_mem.fm[xmv_addr_i[14:0]];
	integer mismatches = 0, samples_checked = 0, seed = 40, k;
	flash_write_erase_control #(.WRITE_CYCLES(8), .ERASE_CYCLES(16)) i_dut (.*);
	mem_side_model i_mem (.*);
	initial forever #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) es <= es | (flash_err_reset_o === 1'b1);
	task b(input w, input [3:0] ad, input [7:0] dt);
		@(posedge mclk_i);
		{avs_write_i, avs_read_i, avs_address_i, avs_writedata_i} <= {w, !w, ad, 24'h0, dt};
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		r = avs_readdata_o;
		{avs_write_i, avs_read_i} <= 2'b00;
	endtask
	task m(input w, input [7:0] dt);
		@(posedge mclk_i);
		{xmv_req_i, xmv_we_i, xmv_wdata_i} <= {1'b1, w, dt};
		do @(posedge mclk_i); while (xmv_ack_o !== 1'b1);
		r = xmv_rdata_o;
		xmv_req_i <= 0;
	endtask
	task unlock;
		b(1, 4'h4, 8'ha5);
		repeat ($random(seed) & 15) @(posedge mclk_i);
		b(1, 4'h4, 8'hf1);
	endtask
	task op(input [1:0] c, input [7:0] dt);
		unlock;
		b(1, 4'h0, c);
		m(1, dt);
		b(0, 4'h8, 0);
		`C(r[0], 1'b1)
		for (k = 0; k < 99 && r[0]; k++) b(0, 4'h8, 0);
		`C(r[0], 1'b0)
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#500000 mismatches++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1;
		xmv_addr_i <= $random(seed) & 16'h3dff;
		b(0, 4'h8, 0);
		k = r;
		b(0, 4'hc, 0);
		`C({k, r}, 64'h0)
		d = $random(seed);
		m(1, d);
		b(1, 4'h0, 1);
		m(0, 0);
		`C({r[7:0], fb}, {d, 8'hff})
		ev = $random(seed);
		op(1, ev);
		`C(fb, ev)
		d = $random(seed);
		op(1, d);
		b(0, 4'h0, 0);
		`C({r[0], fb}, {1'b1, ev & d})
		op(3, 0);
		`C(fb, 8'hff)
		b(1, 4'h0, 1);
		vdd_mon_en_i <= 0;
		unlock;
		m(1, 0);
		repeat (4) @(posedge mclk_i);
		`C({es, fb}, 9'h1ff)
		vdd_mon_en_i <= 1;
		b(1, 4'h4, 8'hf1);
		b(0, 4'h8, 0);
		`C(r[1], 1'b1)
		unlock;
		m(1, 0);
		repeat (20) @(posedge mclk_i);
		`C(fb, 8'hff)
		end_of_test;
	end
endmodule // flash_write_erase_control_tb
bind flash_write_erase_control flash_write_erase_control_props #(.PAGE_W(PAGE_W)) i_props (.*);
